// ---- src/queue_flow_map.svh ----
// What this block does
// RULE_01: Low five address bits pick one queue.
// RULE_02: Selected only when top three bits match identity.
// RULE_03: Controller addresses eight distinct devices at most.
// RULE_04: Address plus strobe picks almost-full bus group.
// RULE_05: Width pins latched at reset per table.
// RULE_06: Narrow words packed little-endian into long words.
// RULE_07: Full counted in write-port units.
// RULE_08: Output valid counted in read-port units.
// RULE_09: One width pair shared by all queues.
// RULE_10: Full flag shows only selected write queue.
// RULE_11: Full flag shows new queue next edge.
// RULE_12: First write on second edge after selection.
// RULE_13: Full flag changes only on clock edges.
// RULE_14: Full flag driven only on identity match.
// RULE_15: Controller ties full flags, addresses one device.
// RULE_16: Valid flag updates with output register load.
// RULE_17: After last word, valid drops on next read.
// RULE_18: New read queue data two cycles after selection.
// RULE_19: Old queue words keep flowing meanwhile.
// RULE_20: Valid flag changes only on clock edges.
// RULE_21: Valid flag driven only on read identity match.
// RULE_22: Both flags active low.
`ifndef QUEUE_FLOW_MAP_SVH
`define QUEUE_FLOW_MAP_SVH

`define ADDR_BITS 8
`define QSEL_BITS 5
`define ID_BITS 3
`define ID_LSB 5
`define QUEUE_COUNT 32
`define DATA_BITS 36
`define UNIT_BITS 9
`define UNITS_PER_WORD 4
`define QUEUE_UNITS 5'h10
`define CNT_BITS 5
`define PTR_BITS 4
`define AF_BUS_BITS 8
`define AF_GROUP_LSB 3
`define AF_FREE_WORDS 3'h2
`define WRITE_HOLD_CYCLES 2'h2

`endif

// ---- src/queue_flow_pkg.sv ----
`include "queue_flow_map.svh"

package queue_flow_pkg;

	typedef enum logic [1:0] {PW_36, PW_18, PW_9} port_width_t;

	// Nine-bit units moved by one transfer at this width
	function automatic logic [2:0] unit_count(input port_width_t w);
		unique case (w)
			PW_36: unit_count = 3'h4;
			PW_18: unit_count = 3'h2;
			PW_9: unit_count = 3'h1;
			default: unit_count = 3'h4;
		endcase
	endfunction

	function automatic logic [`CNT_BITS-1:0] free_units(input logic [`CNT_BITS-1:0] cnt);
		free_units = `QUEUE_UNITS - cnt;
	endfunction

	function automatic logic is_full(input logic [`CNT_BITS-1:0] cnt, input port_width_t w);
		is_full = free_units(cnt) < {2'h0, unit_count(w)};
	endfunction

endpackage

// ---- src/queue_flow_if.sv ----
`timescale 1ns/100ps
`include "queue_flow_map.svh"

interface queue_flow_if;
	logic [`ADDR_BITS-1:0] write_queue_address;
	logic write_select_strobe;
	logic write_enable_n;
	logic [`DATA_BITS-1:0] write_data;
	logic almost_full_bus_strobe;
	logic [`ADDR_BITS-1:0] read_queue_address;
	logic read_select_strobe;
	logic read_enable_n;
	logic [`DATA_BITS-1:0] read_data;
	logic queue_full_flag_n_drv;
	logic queue_full_flag_oe;
	logic output_valid_flag_n_drv;
	logic output_valid_flag_oe;
	logic [`AF_BUS_BITS-1:0] almost_full_flag_bus_n;
	// Shared flag wires, pulled high when nobody drives
	logic queue_full_flag_n;
	logic output_valid_flag_n;

	assign queue_full_flag_n = queue_full_flag_oe ? queue_full_flag_n_drv : 1'b1;
	assign output_valid_flag_n = output_valid_flag_oe ? output_valid_flag_n_drv : 1'b1;

	modport device (
		input write_queue_address, write_select_strobe, write_enable_n, write_data,
		input almost_full_bus_strobe, read_queue_address, read_select_strobe, read_enable_n,
		output read_data, queue_full_flag_n_drv, queue_full_flag_oe,
		output output_valid_flag_n_drv, output_valid_flag_oe, almost_full_flag_bus_n
	);

	modport controller (
		output write_queue_address, write_select_strobe, write_enable_n, write_data,
		output almost_full_bus_strobe, read_queue_address, read_select_strobe, read_enable_n,
		input read_data, queue_full_flag_n, output_valid_flag_n, almost_full_flag_bus_n
	);
endinterface

// ---- src/queue_flow_device.sv ----
`timescale 1ns/100ps
`include "queue_flow_map.svh"

module queue_flow_device (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Static straps
	input wire logic chip_identity_bit0_in,
	input wire logic chip_identity_bit1_in,
	input wire logic chip_identity_bit2_in,
	input wire logic width_match_select_in,
	input wire logic input_width_select_in,
	input wire logic output_width_select_in,
	// Port toward the controller
	queue_flow_if.device port
);

	typedef struct packed {
		// Strap pins, first and second synchroniser stage
		logic [5:0] strap_m;
		logic [5:0] strap_s;
		queue_flow_pkg::port_width_t wport;
		queue_flow_pkg::port_width_t rport;
		logic [`ID_BITS-1:0] chip_id;
		logic [`QSEL_BITS-1:0] wq;
		logic wsel;
		logic whold;
		logic [`QSEL_BITS-1:0] rq_pend;
		logic rsel_pend;
		logic [`QSEL_BITS-1:0] rq;
		logic rsel;
		logic [`QUEUE_COUNT-1:0][`CNT_BITS-1:0] cnt;
		logic [`QUEUE_COUNT-1:0][`PTR_BITS-1:0] wptr;
		logic [`QUEUE_COUNT-1:0][`PTR_BITS-1:0] rptr;
		logic ff_n;
		logic ff_oe;
		logic ov_n;
		logic ov_oe;
		logic [`DATA_BITS-1:0] qdata;
		logic [`AF_BUS_BITS-1:0] af_bus_n;
	} dev_state_t;

	dev_state_t r;
	dev_state_t s;
	// Queue storage kept outside the struct; too large to shuffle through it
	logic [`UNIT_BITS-1:0] mem [0:`QUEUE_COUNT-1][0:`QUEUE_UNITS-1];

	logic [2:0] wun;
	logic [2:0] run;
	logic wr_ok;
	logic rd_load;
	logic rd_ok;
	logic [`DATA_BITS-1:0] rd_word;
	// Raw strap pins; only the first flop stage reads them
	logic [5:0] strap_pins;

	function automatic logic id_match(input logic [`ADDR_BITS-1:0] a, input logic [`ID_BITS-1:0] id);
		id_match = a[`ADDR_BITS-1:`ID_LSB] == id;
	endfunction

	always_comb begin
		strap_pins = {width_match_select_in, input_width_select_in, output_width_select_in,
			chip_identity_bit2_in, chip_identity_bit1_in, chip_identity_bit0_in};
		wun = queue_flow_pkg::unit_count(r.wport); // see RULE_07
		run = queue_flow_pkg::unit_count(r.rport); // see RULE_08
		// Overflow writes are dropped, not stored
		wr_ok = !port.write_enable_n && r.wsel && !r.whold &&
			!queue_flow_pkg::is_full(r.cnt[r.wq], r.wport); // see RULE_12
		// First word falls through: an empty output register loads on its own
		rd_load = !port.read_enable_n || r.ov_n; // see RULE_17
		rd_ok = rd_load && r.rsel && (r.cnt[r.rq] >= {2'h0, run}); // see RULE_08
		rd_word = '0;
		for (int i = 0; i < `UNITS_PER_WORD; i++) begin
			if (i < int'(run)) begin
				rd_word[i*`UNIT_BITS +: `UNIT_BITS] =
					mem[r.rq][r.rptr[r.rq] + `PTR_BITS'(i)]; // see RULE_06
			end
		end
	end

	always_comb begin
		s = r;
		// Straps come from pins, so two flops before any decode
		s.strap_m = strap_pins;
		s.strap_s = r.strap_m;
		s.whold = 1'b0;
		if (port.write_select_strobe) begin
			s.wq = port.write_queue_address[`QSEL_BITS-1:0]; // see RULE_01
			s.wsel = id_match(port.write_queue_address, r.chip_id); // see RULE_02
			s.whold = 1'b1; // see RULE_12
		end
		if (port.read_select_strobe) begin
			s.rq_pend = port.read_queue_address[`QSEL_BITS-1:0];
			s.rsel_pend = id_match(port.read_queue_address, r.chip_id);
		end
		// Second stage of the read switch, so new data lands two edges out
		s.rq = r.rq_pend; // see RULE_18
		s.rsel = r.rsel_pend;
		s.ov_oe = r.rsel_pend; // see RULE_21
		for (int q = 0; q < `QUEUE_COUNT; q++) begin
			if (wr_ok && r.wq == `QSEL_BITS'(q)) begin
				s.cnt[q] = s.cnt[q] + {2'h0, wun};
				s.wptr[q] = r.wptr[q] + `PTR_BITS'(wun);
			end
			if (rd_ok && r.rq == `QSEL_BITS'(q)) begin
				s.cnt[q] = s.cnt[q] - {2'h0, run};
				s.rptr[q] = r.rptr[q] + `PTR_BITS'(run);
			end
		end
		if (rd_ok) begin
			s.qdata = rd_word; // see RULE_16
			s.ov_n = 1'b0; // see RULE_22
		end else if (rd_load) begin
			s.ov_n = 1'b1; // see RULE_17
		end
		// Flag taken from updated counts of the queue captured last edge
		s.ff_n = !queue_flow_pkg::is_full(s.cnt[r.wq], r.wport); // see RULE_10
		s.ff_oe = r.wsel; // see RULE_14
		if (port.almost_full_bus_strobe && id_match(port.write_queue_address, r.chip_id)) begin
			for (int i = 0; i < `AF_BUS_BITS; i++) begin
				s.af_bus_n[i] = queue_flow_pkg::free_units(
					s.cnt[{port.write_queue_address[`QSEL_BITS-1:`AF_GROUP_LSB], 3'(i)}]) >=
					{2'h0, wun} * {2'h0, `AF_FREE_WORDS}; // see RULE_04
			end
		end
		if (rst_in) begin
			s = '0;
			// Synchroniser keeps running through reset; straps settle within two edges
			s.strap_m = strap_pins;
			s.strap_s = r.strap_m;
			s.chip_id = r.strap_s[2:0];
			s.wport = queue_flow_pkg::PW_36;
			s.rport = queue_flow_pkg::PW_36;
			// Last reset edge wins; reset must outlast the synchroniser
			if (r.strap_s[5]) begin
				unique case (r.strap_s[4:3])
					2'h0: s.rport = queue_flow_pkg::PW_18; // see RULE_05
					2'h1: s.rport = queue_flow_pkg::PW_9;
					2'h2: s.wport = queue_flow_pkg::PW_18;
					2'h3: s.wport = queue_flow_pkg::PW_9;
				endcase
			end
			s.ff_n = 1'b1;
			s.ov_n = 1'b1;
			s.af_bus_n = '1;
		end
	end

	// All flags move only here, on the clock edge
	always_ff @(posedge mclk_in) begin
		r <= s; // see RULE_13 RULE_20 RULE_09
	end

	always_ff @(posedge mclk_in) begin
		if (wr_ok) begin
			for (int i = 0; i < `UNITS_PER_WORD; i++) begin
				if (i < int'(wun)) begin
					mem[r.wq][r.wptr[r.wq] + `PTR_BITS'(i)] <=
						port.write_data[i*`UNIT_BITS +: `UNIT_BITS]; // see RULE_06
				end
			end
		end
	end

	assign port.read_data = r.qdata;
	assign port.queue_full_flag_n_drv = r.ff_n;
	assign port.queue_full_flag_oe = r.ff_oe;
	assign port.output_valid_flag_n_drv = r.ov_n;
	assign port.output_valid_flag_oe = r.ov_oe;
	assign port.almost_full_flag_bus_n = r.af_bus_n;

endmodule

// ---- src/queue_flow_controller.sv ----
`timescale 1ns/100ps
`include "queue_flow_map.svh"

module queue_flow_controller (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Write side requests
	input wire logic usr_wsel_in,
	input wire logic [`ADDR_BITS-1:0] usr_wq_in,
	input wire logic usr_wr_in,
	input wire logic [`DATA_BITS-1:0] usr_wdata_in,
	input wire logic usr_af_poll_in,
	output logic usr_wready_out,
	output logic [`AF_BUS_BITS-1:0] usr_af_flags_n_out,
	// Read side requests
	input wire logic usr_rsel_in,
	input wire logic [`ADDR_BITS-1:0] usr_rq_in,
	input wire logic usr_rd_in,
	output logic [`DATA_BITS-1:0] usr_rdata_out,
	output logic usr_rvalid_out,
	// Port toward the devices
	queue_flow_if.controller port
);

	typedef struct packed {
		logic [`ADDR_BITS-1:0] wq;
		logic wstrobe;
		logic af_strobe;
		logic wen_n;
		logic [`DATA_BITS-1:0] wdata;
		logic [1:0] hold;
		logic wready;
		logic [`AF_BUS_BITS-1:0] af_n;
		logic [`ADDR_BITS-1:0] rq;
		logic rstrobe;
		logic ren_n;
		logic [`DATA_BITS-1:0] rdata;
		logic rvalid;
	} ctl_state_t;

	ctl_state_t r;
	ctl_state_t s;

	always_comb begin
		s = r;
		s.wstrobe = 1'b0;
		s.af_strobe = 1'b0;
		s.wen_n = 1'b1;
		s.rstrobe = 1'b0;
		s.ren_n = 1'b1;
		if (r.hold != 2'h0) begin
			s.hold = r.hold - 2'h1;
		end
		// Full address drives every device; only the matching one answers
		if (usr_wsel_in) begin
			s.wq = usr_wq_in; // see RULE_03 RULE_15
			s.wstrobe = 1'b1;
			s.hold = `WRITE_HOLD_CYCLES; // see RULE_12
		end else if (usr_af_poll_in) begin
			s.wq = usr_wq_in;
			s.af_strobe = 1'b1; // see RULE_04
		end
		if (usr_wr_in && r.wready && !usr_wsel_in) begin
			s.wen_n = 1'b0;
			s.wdata = usr_wdata_in;
		end
		// Ready trails the shared flag by a cycle; device drops overflow
		s.wready = (s.hold == 2'h0) && port.queue_full_flag_n && !usr_wsel_in; // see RULE_15
		s.af_n = port.almost_full_flag_bus_n;
		if (usr_rsel_in) begin
			s.rq = usr_rq_in;
			s.rstrobe = 1'b1;
		end
		if (usr_rd_in) begin
			s.ren_n = 1'b0;
		end
		s.rdata = port.read_data;
		s.rvalid = !port.output_valid_flag_n; // see RULE_22
		if (rst_in) begin
			s = '0;
			s.wen_n = 1'b1;
			s.ren_n = 1'b1;
			s.af_n = '1;
		end
	end

	always_ff @(posedge mclk_in) begin
		r <= s;
	end

	assign port.write_queue_address = r.wq;
	assign port.write_select_strobe = r.wstrobe;
	assign port.write_enable_n = r.wen_n;
	assign port.write_data = r.wdata;
	assign port.almost_full_bus_strobe = r.af_strobe;
	assign port.read_queue_address = r.rq;
	assign port.read_select_strobe = r.rstrobe;
	assign port.read_enable_n = r.ren_n;
	assign usr_wready_out = r.wready;
	assign usr_af_flags_n_out = r.af_n;
	assign usr_rdata_out = r.rdata;
	assign usr_rvalid_out = r.rvalid;

endmodule

// ---- tb/queue_flow_sva.sv ----
`timescale 1ns/100ps
`include "queue_flow_map.svh"

module queue_flow_sva #(parameter int ID = 2) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Interface signals
	input wire logic [`ADDR_BITS-1:0] write_queue_address,
	input wire logic write_select_strobe,
	input wire logic almost_full_bus_strobe,
	input wire logic [`ADDR_BITS-1:0] read_queue_address,
	input wire logic read_select_strobe,
	input wire logic read_enable_n,
	input wire logic [`DATA_BITS-1:0] read_data,
	input wire logic queue_full_flag_oe,
	input wire logic output_valid_flag_n_drv,
	input wire logic output_valid_flag_oe,
	input wire logic [`AF_BUS_BITS-1:0] almost_full_flag_bus_n
);
	// Last read selection hit this device
	logic rmatch_r;
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rmatch_r <= 1'b0;
		end else if (read_select_strobe) begin
			rmatch_r <= read_queue_address[7:5] == 3'(ID);
		end
	end
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	ff_sel_a: assert property (write_select_strobe |-> ##2
		queue_full_flag_oe == ($past(write_queue_address[7:5], 2) == 3'(ID)))
		else $error("full flag drive wrong after select");
	ff_keep_a: assert property (!write_select_strobe && !$past(write_select_strobe) |=>
		$stable(queue_full_flag_oe)) else $error("full flag drive moved without select");
	ov_sel_a: assert property (read_select_strobe |-> ##2
		output_valid_flag_oe == ($past(read_queue_address[7:5], 2) == 3'(ID)))
		else $error("valid flag drive wrong after select");
	ov_drv_a: assert property (!$past(read_select_strobe) |->
		output_valid_flag_oe == rmatch_r) else $error("valid flag drive lost");
	data_load_a: assert property (!$stable(read_data) |->
		$past(!read_enable_n || output_valid_flag_n_drv)) else $error("data moved without load");
	ov_load_a: assert property (!$stable(output_valid_flag_n_drv) |->
		$past(!read_enable_n || output_valid_flag_n_drv)) else $error("valid moved without load");
	word_hold_a: assert property (read_enable_n && !output_valid_flag_n_drv |=>
		$stable(read_data) && !output_valid_flag_n_drv) else $error("valid word not held");
	af_hold_a: assert property (!almost_full_bus_strobe |=>
		$stable(almost_full_flag_bus_n)) else $error("flag bus moved without strobe");
	cover property (write_select_strobe ##1 queue_full_flag_oe);
	cover property (read_select_strobe ##1 output_valid_flag_oe);
	cover property ($fell(output_valid_flag_n_drv));
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`include "queue_flow_map.svh"

module tb;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic bm = 1'b0, iw = 1'b0, ow = 1'b0;
	logic wsel = 1'b0, wr = 1'b0, rsel = 1'b0, rd = 1'b0;
	logic [7:0] wq = 8'h00, rq = 8'h00;
	logic [35:0] wd = 36'h0;
	logic afp = 1'b0;
	logic wro, rvo;
	logic [7:0] afo;
	logic [35:0] rdo;
	logic [35:0] w [4];
	int fails = 0, cmp_count = 0;
	queue_flow_if port_if();
	always #50 mclk_in = ~mclk_in;
	// Identity strapped to two
	queue_flow_device u_queue_flow_device (.mclk_in(mclk_in), .rst_in(rst_in),
		.chip_identity_bit0_in(1'b0), .chip_identity_bit1_in(1'b1), .chip_identity_bit2_in(1'b0),
		.width_match_select_in(bm), .input_width_select_in(iw), .output_width_select_in(ow),
		.port(port_if));
	queue_flow_controller u_queue_flow_controller (.mclk_in(mclk_in), .rst_in(rst_in),
		.usr_wsel_in(wsel), .usr_wq_in(wq), .usr_wr_in(wr), .usr_wdata_in(wd),
		.usr_af_poll_in(afp), .usr_wready_out(wro), .usr_af_flags_n_out(afo), .usr_rsel_in(rsel),
		.usr_rq_in(rq), .usr_rd_in(rd), .usr_rdata_out(rdo), .usr_rvalid_out(rvo), .port(port_if));
	queue_flow_sva #(.ID(2)) u_sva (.mclk_in(mclk_in), .rst_in(rst_in),
		.write_queue_address(port_if.write_queue_address),
		.write_select_strobe(port_if.write_select_strobe),
		.almost_full_bus_strobe(port_if.almost_full_bus_strobe),
		.read_queue_address(port_if.read_queue_address),
		.read_select_strobe(port_if.read_select_strobe), .read_enable_n(port_if.read_enable_n),
		.read_data(port_if.read_data), .queue_full_flag_oe(port_if.queue_full_flag_oe),
		.output_valid_flag_n_drv(port_if.output_valid_flag_n_drv),
		.output_valid_flag_oe(port_if.output_valid_flag_oe),
		.almost_full_flag_bus_n(port_if.almost_full_flag_bus_n));

	task automatic results();
		$display("Compares %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Inputs always move one step after the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task automatic reset(input logic b, input logic i, input logic o);
		rst_in = 1'b1;
		{bm, iw, ow} = {b, i, o};
		cyc(12);
		rst_in = 1'b0;
		cyc(2);
	endtask
	// Bounded wait for ready or a valid word
	task automatic wt(input bit for_ov);
		for (int k = 0; k < 30; k++) begin
			if (for_ov ? port_if.output_valid_flag_n === 1'b0 : wro === 1'b1) begin
				return;
			end
			cyc(1);
		end
		fails++;
		$display("[ERR] %0t wait ran out", $time);
		results();
	endtask
	task automatic wsel_t(input logic [7:0] a);
		wq = a;
		wsel = 1'b1;
		cyc(1);
		wsel = 1'b0;
		cyc(4);
	endtask
	task automatic rsel_t(input logic [7:0] a);
		rq = a;
		rsel = 1'b1;
		cyc(1);
		rsel = 1'b0;
		cyc(4);
	endtask
	task automatic wr_t(input logic [35:0] d);
		wt(0);
		wd = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		cyc(1);
	endtask
	// One enabled read, one load
	task automatic rd_t();
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		cyc(3);
	endtask
	task automatic t_full();
		for (int i = 0; i < 4; i++) begin
			w[i] = 36'h1_2345_6780 + 36'(i);
		end
		wsel_t(8'h45);
		chk(36'(port_if.queue_full_flag_oe), 36'h1);
		chk(36'(port_if.queue_full_flag_n), 36'h1);
		for (int i = 0; i < 4; i++) begin
			wr_t(w[i]);
		end
		cyc(2);
		chk(36'(port_if.queue_full_flag_n), 36'h0);
		wsel_t(8'h46);
		chk(36'(port_if.queue_full_flag_n), 36'h1);
		wsel_t(8'h65);
		chk(36'(port_if.queue_full_flag_oe), 36'h0);
		wsel_t(8'h45);
		chk(36'(port_if.queue_full_flag_n), 36'h0);
		// Poll group of queues 0..7: only queue 5 lacks room
		afp = 1'b1;
		cyc(1);
		afp = 1'b0;
		cyc(3);
		chk(36'(port_if.almost_full_flag_bus_n), 36'hdf);
		chk(36'(afo), 36'hdf);
		rsel_t(8'h45);
		for (int i = 0; i < 4; i++) begin
			wt(1);
			chk(port_if.read_data, w[i]);
			chk(rdo, w[i]);
			chk(36'(rvo), 36'h1);
			rd_t();
		end
		chk(36'(port_if.output_valid_flag_n), 36'h1);
		chk(36'(port_if.queue_full_flag_n), 36'h1);
		rsel_t(8'h65);
		chk(36'(port_if.output_valid_flag_oe), 36'h0);
	endtask
	// Long words in, bytes out
	task automatic t_narrow_out();
		reset(1'b1, 1'b0, 1'b1);
		wsel_t(8'h40);
		for (int i = 0; i < 4; i++) begin
			wr_t(w[i]);
		end
		rsel_t(8'h40);
		for (int k = 0; k < 4; k++) begin
			wt(1);
			cyc(2);
			chk(port_if.read_data, {27'h0, w[0][9*k +: 9]});
			chk(36'(port_if.queue_full_flag_n), 36'(k == 3));
			rd_t();
		end
	endtask
	// Half words in: valid needs a full long word
	task automatic t_narrow_in();
		reset(1'b1, 1'b1, 1'b0);
		rsel_t(8'h41);
		wsel_t(8'h41);
		wr_t(36'h0_0001_2345);
		cyc(3);
		chk(36'(port_if.output_valid_flag_n), 36'h1);
		wr_t(36'h0_0002_abcd);
		wt(1);
		chk(port_if.read_data, {18'h2abcd, 18'h12345});
	endtask

	initial begin
		reset(1'b0, 1'b0, 1'b0);
		t_full();
		t_narrow_out();
		t_narrow_in();
		results();
	end
endmodule
